// *** rtl/pgx_walker.sv ***
// Purpose: Walk directories and tables to translate one linear address
// Assumes: Memory answers reads with mem_valid, short words in low 32 bits
// Notes: Every output but avs_waitrequest comes from the single state register
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module pgx_walker
    import pgx_pkg::*;
#(
    parameter bit WIDE_FEATURE = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [35:0] mem_addr,
    output logic mem_read,
    input wire logic mem_valid,
    input wire logic [63:0] mem_rdata
);
    // All walker state lives in one struct: q is the register, d its
    // next value. The bus side and the walk side both edit d in the one
    // combinational process, so each field has a single driver.
    // Hazard: control writes during a walk take effect at once, so
    // software must wait for busy to clear before changing modes.
    pgx_regs_t q, d;

    // Physical address of a 4K page: frame from entry plus offset
    function automatic logic [35:0] frame_4k(input logic [35:0] ent,
        input logic [31:0] la);
        frame_4k = {ent[35:12], la[11:0]};
    endfunction

    // Pointer slot: four 8-byte entries, picked by the top two
    // linear bits; the base is 32-byte aligned
    function automatic logic [35:0] ptr_addr(input logic [31:0] base,
        input logic [31:0] la);
        ptr_addr = {4'h0, base[31:5], la[31:30], 3'h0};
    endfunction

    // Directory slot: 32-bit entries normally, 64-bit when extended;
    // the extended directory base comes from the pointer entry
    function automatic logic [35:0] dir_addr(input logic ext,
        input logic [35:0] tbase,
        input logic [31:0] base,
        input logic [31:0] la);
        logic [35:0] a;
        if (ext)
            a = {tbase[35:12], la[29:21], 3'h0};
        else
            a = {4'h0, base[31:12], la[31:22], 2'h0};
        dir_addr = a;
    endfunction

    // Table slot: 1024 short entries or 512 long ones;
    // the table base was taken from the directory entry
    function automatic logic [35:0] tbl_addr(input logic ext,
        input logic [35:0] tbase,
        input logic [31:0] la);
        logic [35:0] a;
        if (ext)
            a = {tbase[35:12], la[20:12], 3'h0};
        else
            a = {tbase[35:12], la[21:12], 2'h0};
        tbl_addr = a;
    endfunction

    // 2M page: frame from bits 35:21 of the long entry,
    // offset from the low 21 linear bits
    function automatic logic [35:0] phys_2m(input logic [63:0] ent,
        input logic [31:0] la);
        phys_2m = {ent[35:21], la[20:0]};
    endfunction

    // 4M page: upper frame bits only when the wide feature exists;
    // without it they read as zero and the page stays below 4 GBytes
    function automatic logic [35:0] phys_4m(input logic [63:0] ent,
        input logic [31:0] la);
        logic [3:0] hi;
        hi = WIDE_FEATURE ? ent[16:13] : 4'h0;
        phys_4m = {hi, ent[31:22], la[21:0]};
    endfunction

    // Status word: wide, size, fault, spare zero, busy;
    // the spare bit keeps the field layout stable for software
    function automatic logic [31:0] status_word(input pgx_regs_t r);
        status_word = {26'h0, r.wide, r.size, r.fault, 1'b0, r.busy};
    endfunction

    // Register window read; unmapped words read as zero so software
    // probing past the end sees a clean value rather than stale data
    function automatic logic [31:0] reg_read(input pgx_regs_t r,
        input logic [3:0] a);
        logic [31:0] v;
        case (a)
            PGX_OFF_CR0: v = r.cr0;
            PGX_OFF_CR4: v = r.cr4;
            PGX_OFF_DIR_BASE: v = r.dir_base;
            PGX_OFF_LIN: v = r.lin;
            PGX_OFF_STAT: v = status_word(r);
            PGX_OFF_PHYS_LO: v = r.phys[31:0];
            PGX_OFF_PHYS_HI: v = {28'h0, r.phys[35:32]};
            PGX_OFF_QUERY: v = 32'(WIDE_FEATURE) << PGX_BIT_WIDE;
            default: v = PGX_UNMAPPED;
        endcase
        reg_read = v;
    endfunction

    // How a walk runs
    //
    // Software loads control_reg_zero, control_reg_four, the directory
    // base and the linear address, then writes 1 to bit 0 of the
    // control word. The start is taken only while busy is clear.
    //
    // With translation off the linear address is copied out as the
    // physical address in one step, whatever the extension bits say.
    //
    // With translation on and the address extension clear, the walk
    // reads one 32-bit directory entry. A set large flag together with
    // the size extension ends the walk there with a 4M page; otherwise
    // the entry names a page table and one more 32-bit read follows.
    //
    // With the address extension set, the walk first reads one of the
    // four 64-bit pointer entries, then a 64-bit directory entry, and
    // for small pages a 64-bit table entry. A set large flag ends the
    // walk at the directory with a 2M page.
    //
    // Memory side
    //
    // mem_read rises together with mem_addr and both hold until the
    // cycle in which mem_valid is seen. The read drops on the next
    // edge, so a reply can never be taken twice. Short entries sit in
    // the low half of mem_rdata; the high half is ignored for them.
    //
    // Bus side
    //
    // Every request sees one wait cycle. Read data are latched on the
    // first edge and stand until the next read is answered. A write is
    // taken on the second edge, the one where waitrequest is low.
    //
    // Page sizes
    //
    // Size codes read back in the status word are none for a flat
    // copy, then 4K, 2M and 4M. The wide bit marks results that may
    // reach above 4 GBytes.
    //
    // Reset
    //
    // Reset clears every register but the state, which loads idle, so translation starts disabled, the
    // memory read is low and the walk sits idle. The first bus request
    // may come at the first edge after reset is released.
    //
    // Limitations
    //
    // There is no entry cache: every start walks memory afresh. Access
    // rights, accessed and dirty bits are not examined; only the
    // present and large flags are. A missing entry at any level sets
    // the fault bit and clears the size code.
    // Changing the control words while busy is set is not guarded;
    // the walk then mixes old and new settings, so software must wait.

    always_comb
    begin
        logic phys_addr_ext_enable;
        logic page_size_ext_enable;
        logic pg;
        logic lg;
        // Control bits come from the registered copies only
        phys_addr_ext_enable = q.cr4[PGX_BIT_PAE];
        page_size_ext_enable = q.cr4[PGX_BIT_PSE];
        pg = q.cr0[PGX_BIT_PG];
        lg = mem_rdata[PGX_BIT_LARGE];
        d = q;
        d.rvalid = 1'b0;
        d.wait_n = 1'b0;
        // Bus slave: the first edge of a request only raises the wait
        // flag and latches read data; the second edge, where the master
        // sees waitrequest low, is the one that takes a write, so a
        // write never lands before it is accepted
        if ((avs_read || avs_write) && !q.wait_n)
        begin
            d.wait_n = 1'b1;
            if (avs_read)
                d.rdata = reg_read(q, avs_address);
        end
        else if (avs_write && q.wait_n)
        begin
            case (avs_address)
                PGX_OFF_CR0: d.cr0 = avs_writedata;
                PGX_OFF_CR4: d.cr4 = avs_writedata;
                PGX_OFF_DIR_BASE: d.dir_base = avs_writedata;
                PGX_OFF_LIN: d.lin = avs_writedata;
                PGX_OFF_CTRL:
                begin
                    // Start while busy is refused; a walk is never cut
                    if (avs_writedata[0] && !q.busy)
                    begin
                        d.busy = 1'b1;
                        d.fault = 1'b0;
                        d.st = pg ? (phys_addr_ext_enable ? PGX_PTR_RD : PGX_DIR_RD)
                            : PGX_FLAT;
                    end
                end
                default: d.busy = q.busy;
            endcase
        end

        // Translation walk: one state per memory fetch; every fetch
        // holds its address until the reply is taken
        case (q.st)
            // Idle: no memory traffic; a start from the bus side moves
            // the walk on at the same edge that takes the write
            PGX_IDLE:
            begin
                d.mem_read = 1'b0;
            end

            // Flat copy: one cycle, no memory read
            PGX_FLAT:
            begin
                // Paging off: linear passes straight through
                d.phys = {4'h0, q.lin};
                d.size = PGX_SZ_NONE;
                d.wide = 1'b0;
                d.st = PGX_DONE;
            end

            // Extended walk, step one: fetch the pointer entry. A clear
            // present bit ends the walk in the fault state.
            PGX_PTR_RD:
            begin
                // Four 64-bit pointers, picked by top two bits
                d.mem_addr = ptr_addr(q.dir_base, q.lin);
                d.mem_read = 1'b1;
                if (q.mem_read && mem_valid)
                begin
                    d.mem_read = 1'b0;
                    d.tbl_base = {mem_rdata[35:12], 12'h0};
                    d.st = mem_rdata[PGX_BIT_PRESENT] ? PGX_DIR_RD
                        : PGX_FAULT;
                end
            end

            // Directory step: the large flag, with an extension bit set, decides
            // between a direct large page and one more fetch from a page table. Which
            // large size applies follows the address extension bit.
            PGX_DIR_RD:
            begin
                // 1024 x 32-bit entries, or 512 x 64 when extended
                d.mem_addr = dir_addr(phys_addr_ext_enable, q.tbl_base, q.dir_base,
                    q.lin);
                d.mem_read = 1'b1;
                if (q.mem_read && mem_valid)
                begin
                    d.mem_read = 1'b0;
                    if (!mem_rdata[PGX_BIT_PRESENT])
                        d.st = PGX_FAULT;
                    else if (lg && phys_addr_ext_enable)
                    begin
                        d.phys = phys_2m(mem_rdata, q.lin);
                        d.size = PGX_SZ_2M;
                        d.wide = 1'b1;
                        d.st = PGX_DONE;
                    end
                    else if (lg && page_size_ext_enable)
                    begin
                        // Wide frame bits only if feature present
                        d.phys = phys_4m(mem_rdata, q.lin);
                        d.size = PGX_SZ_4M;
                        d.wide = WIDE_FEATURE;
                        d.st = PGX_DONE;
                    end
                    else
                    begin
                        d.tbl_base = phys_addr_ext_enable ? {mem_rdata[35:12], 12'h0}
                            : {4'h0, mem_rdata[31:12], 12'h0};
                        d.st = PGX_TBL_RD;
                    end
                end
            end

            // Table step: always a 4K page; the entry width follows the
            // extension bit latched in control_reg_four
            PGX_TBL_RD:
            begin
                d.mem_addr = tbl_addr(phys_addr_ext_enable, q.tbl_base, q.lin);
                d.mem_read = 1'b1;
                if (q.mem_read && mem_valid)
                begin
                    d.mem_read = 1'b0;
                    d.phys = phys_addr_ext_enable ? frame_4k(mem_rdata[35:0], q.lin)
                        : frame_4k({4'h0, mem_rdata[31:0]}, q.lin);
                    d.size = PGX_SZ_4K;
                    d.wide = phys_addr_ext_enable;
                    d.st = mem_rdata[PGX_BIT_PRESENT] ? PGX_DONE
                        : PGX_FAULT;
                end
            end

            // Fault: report, drop busy, return to idle
            PGX_FAULT:
            begin
                d.fault = 1'b1;
                d.busy = 1'b0;
                d.size = PGX_SZ_NONE;
                d.st = PGX_IDLE;
            end

            // Done: result stands until the next start
            PGX_DONE:
            begin
                d.busy = 1'b0;
                d.st = PGX_IDLE;
            end
            default: d.st = PGX_IDLE;
        endcase
    end

    // State register; async reset to constants only. Reset lands in
    // idle with translation off, so no memory read can start until
    // software has loaded the control words and written a start.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.st <= PGX_IDLE;
        end
        else
            q <= d;
    end

    // Outputs. Read data, memory address and memory read come straight
    // from the state register. waitrequest is the one exception: it is
    // formed from the live request and the registered wait flag, so
    // the first cycle of a request is always stretched without a
    // cycle of delay before the slave can react.
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !q.wait_n;
    assign mem_addr = q.mem_addr;
    assign mem_read = q.mem_read;
endmodule

// *** rtl/pgx_pkg.sv ***
// Purpose: Constants and carriers for the page translation walker
// Assumes: 32-bit Avalon-MM slave, single clock ref_clk at 10 MHz
// Notes: What this block does list follows
// What this block does
// - Directory is 1024 entries of 32 bits, or 512 of 64 bits with extension
// - Table is 1024 entries (512 with extension), each one 4K page
// - Large pages map from directory, no table fetch
// - Pointer table of four 64-bit entries only with extension
// - 32-bit: 4K/4M pages; 36-bit: 4K/2M
// - Large flag clear means entry points to table
// - Size extension plus large flag gives 4M page while address extension is clear
// - Address extension plus large flag gives 2M page
// - No extension gives 32-bit addresses, 4 GBytes, except 4M pages with the wide feature
// - Extension gives 36-bit addresses, 64 GBytes
// - Translate only while translation enable set
// - Translation enable is control_reg_zero bit 31
// - Size ext bit 4, address ext bit 5 of control_reg_four
// - Wide large page feature in query_result_reg bit 17
package pgx_pkg;
    // Register word offsets
    localparam logic [3:0] PGX_OFF_CR0 = 4'h0;
    localparam logic [3:0] PGX_OFF_CR4 = 4'h1;
    localparam logic [3:0] PGX_OFF_DIR_BASE = 4'h2;
    localparam logic [3:0] PGX_OFF_LIN = 4'h3;
    localparam logic [3:0] PGX_OFF_CTRL = 4'h4;
    localparam logic [3:0] PGX_OFF_STAT = 4'h5;
    localparam logic [3:0] PGX_OFF_PHYS_LO = 4'h6;
    localparam logic [3:0] PGX_OFF_PHYS_HI = 4'h7;
    localparam logic [3:0] PGX_OFF_QUERY = 4'h8;
    // Field positions
    localparam int PGX_BIT_PG = 31;
    localparam int PGX_BIT_PSE = 4;
    localparam int PGX_BIT_PAE = 5;
    localparam int PGX_BIT_WIDE = 17;
    localparam int PGX_BIT_LARGE = 7;
    localparam int PGX_BIT_PRESENT = 0;
    localparam logic [31:0] PGX_RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] PGX_UNMAPPED = 32'h0000_0000;
    // Page size codes
    localparam logic [1:0] PGX_SZ_NONE = 2'h0;
    localparam logic [1:0] PGX_SZ_4K = 2'h1;
    localparam logic [1:0] PGX_SZ_2M = 2'h2;
    localparam logic [1:0] PGX_SZ_4M = 2'h3;

    typedef enum logic [6:0] {
        PGX_IDLE = 7'b000_0001,
        PGX_PTR_RD = 7'b000_0010,
        PGX_DIR_RD = 7'b000_0100,
        PGX_TBL_RD = 7'b000_1000,
        PGX_DONE = 7'b001_0000,
        PGX_FAULT = 7'b010_0000,
        PGX_FLAT = 7'b100_0000
    } pgx_state_t;

    typedef struct packed {
        logic [35:0] addr;
        logic read;
    } pgx_mem_req_t;

    typedef struct packed {
        pgx_state_t st;
        logic [31:0] cr0;
        logic [31:0] cr4;
        logic [31:0] dir_base;
        logic [31:0] lin;
        logic [35:0] phys;
        logic [1:0] size;
        logic wide;
        logic fault;
        logic busy;
        logic [35:0] mem_addr;
        logic mem_read;
        logic [31:0] rdata;
        logic rvalid;
        logic wait_n;
        logic [35:0] tbl_base;
    } pgx_regs_t;
endpackage

// *** sim/pgx_walker_asserts.sv ***
// Purpose: Port checks for the page walker
// Assumes: One clock, reset low
// Notes: Enable bit mirrored from taken bus writes
`timescale 1ns/1ps
module pgx_walker_asserts
    import pgx_pkg::*;
#(
    parameter bit WIDE_FEATURE = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [35:0] mem_addr,
    input wire logic mem_read,
    input wire logic mem_valid
);
    logic pg_q;
    logic req;
    logic rd_ok;
    logic wr_ok;
    // Taken transfers
    assign req = avs_read | avs_write;
    assign rd_ok = avs_read & ~avs_waitrequest;
    assign wr_ok = avs_write & ~avs_waitrequest;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    // Mirror of translation enable
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pg_q <= 1'b0;
        else if (wr_ok && avs_address == PGX_OFF_CR0)
            pg_q <= avs_writedata[PGX_BIT_PG];
    end
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait in first cycle");
    a_wait_bound: assert property (req |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");
    a_mem_hold: assert property (mem_read && !mem_valid |=> mem_read)
        else $error("memory read dropped early");
    a_addr_stable: assert property (mem_read && !mem_valid |=> $stable(mem_addr))
        else $error("memory address moved");
    a_mem_drop: assert property (mem_read && mem_valid |=> !mem_read)
        else $error("memory read not released");
    a_entry_align: assert property (mem_read |-> mem_addr[1:0] == 2'h0)
        else $error("entry address unaligned");
    a_query_bit: assert property (rd_ok && avs_address == PGX_OFF_QUERY
        |-> avs_readdata[PGX_BIT_WIDE] == WIDE_FEATURE)
        else $error("feature bit wrong");
    a_unmapped_zero: assert property (rd_ok && avs_address > PGX_OFF_QUERY
        |-> avs_readdata == PGX_UNMAPPED)
        else $error("unmapped read not zero");
    a_no_walk_off: assert property ($rose(mem_read) |-> pg_q)
        else $error("walk with paging off");
    c_walk: cover property (mem_read && mem_valid);
    c_query: cover property (rd_ok && avs_address == PGX_OFF_QUERY);
    c_unmapped: cover property (rd_ok && avs_address > PGX_OFF_QUERY);
endmodule
bind pgx_walker pgx_walker_asserts #(.WIDE_FEATURE(WIDE_FEATURE)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
    .mem_read(mem_read), .mem_valid(mem_valid));

// *** sim/pgx_mem_model.sv ***
// Purpose: Memory holding directories, tables, pointer entries
// Assumes: Walker holds mem_read until mem_valid
// Notes: Idle data is inverted so stale words never match
`timescale 1ns/1ps
module pgx_mem_model
(
    input wire logic ref_clk,
    input wire logic mem_read,
    input wire logic [35:0] mem_addr,
    output logic mem_valid,
    output logic [63:0] mem_rdata
);
    logic [63:0] store [logic [35:0]];
    int reads = 0;
    int lag = 0;
    // Prompt and slow answers alternate
    initial
    begin
        mem_valid = 1'b0;
        mem_rdata = 64'h0;
        forever
        begin
            @(posedge ref_clk);
            if (mem_read && !mem_valid)
            begin
                repeat (lag) @(posedge ref_clk);
                lag = 2 - lag;
                reads++;
                mem_valid <= 1'b1;
                mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : 64'h0;
            end
            else
            begin
                // Idle or just answered: drop valid, scramble the data
                mem_valid <= 1'b0;
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule

// *** sim/pgx_walker_tb.sv ***
// Purpose: Self-checking bench for the page walker
// Assumes: Memory model answers after 1 or 3 cycles
// Notes: Each bus request starts one edge after release
`timescale 1ns/1ps
module pgx_walker_tb
    import pgx_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [35:0] mem_addr;
    logic mem_read;
    logic mem_valid;
    logic [63:0] mem_rdata;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    pgx_walker dut (.ref_clk(ref_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mem_addr(mem_addr), .mem_read(mem_read),
        .mem_valid(mem_valid), .mem_rdata(mem_rdata));
    pgx_mem_model mem (.ref_clk(ref_clk), .mem_read(mem_read),
        .mem_addr(mem_addr), .mem_valid(mem_valid),
        .mem_rdata(mem_rdata));
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Hang guard, well above the run's roughly 130 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [35:0] e, s);
        cmp_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Held until the edge that samples waitrequest low
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge ref_clk iff !avs_waitrequest);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge ref_clk iff !avs_waitrequest);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic walk(input logic [31:0] c0, c4, ln,
            input logic [35:0] ep, input logic [1:0] es, input int nr);
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] st;
        int n;
        n = mem.reads;
        bus_wr(PGX_OFF_CR0, c0);
        bus_wr(PGX_OFF_CR4, c4);
        bus_wr(PGX_OFF_DIR_BASE, 32'h0000_1000);
        bus_wr(PGX_OFF_LIN, ln);
        bus_wr(PGX_OFF_CTRL, 32'h0000_0001);
        st = 32'h0000_0001;
        for (int i = 0; i < 40 && st[0] !== 1'b0; i++)
            bus_rd(PGX_OFF_STAT, st);
        bus_rd(PGX_OFF_PHYS_LO, lo);
        bus_rd(PGX_OFF_PHYS_HI, hi);
        chk("phys", ep, {hi[3:0], lo});
        chk("size", {34'h0, es}, {34'h0, st[4:3]});
        chk("fault", 36'h0, {35'h0, st[2]});
        chk("reads", 36'(nr), 36'(mem.reads - n));
    endtask
    task automatic t_query();
        logic [31:0] d;
        bus_rd(PGX_OFF_QUERY, d);
        chk("wide", 36'h1, {35'h0, d[PGX_BIT_WIDE]});
        bus_rd(4'h9, d);
        chk("unmapped", 36'h0, {4'h0, d});
    endtask
    // Extensions set but paging off: linear passes through
    task automatic t_flat();
        walk(32'h0, 32'h30, 32'h8040_3abc, 36'h0_8040_3abc,
            PGX_SZ_NONE, 0);
    endtask
    // Size extension on, large flag clear: still a table walk
    task automatic t_4k();
        mem.store[36'h0_0000_1004] = 64'h0000_2001;
        mem.store[36'h0_0000_200c] = 64'h5000_0001;
        walk(32'h8000_0000, 32'h10, 32'h0040_3abc,
            36'h0_5000_0abc, PGX_SZ_4K, 2);
    endtask
    task automatic t_4m();
        mem.store[36'h0_0000_1004] = 64'h0080_0081;
        walk(32'h8000_0000, 32'h10, 32'h0040_3abc,
            36'h0_0080_3abc, PGX_SZ_4M, 1);
    endtask
    task automatic t_2m();
        mem.store[36'h0_0000_1008] = 64'h0000_3001;
        mem.store[36'h0_0000_3010] = 64'h0000_0001_0060_0081;
        walk(32'h8000_0000, 32'h20, 32'h4040_3abc,
            36'h1_0060_3abc, PGX_SZ_2M, 2);
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_query();
        t_flat();
        t_4k();
        t_4m();
        t_2m();
        close_out();
    end
endmodule
